// *** hw/event_notifier_pkg.sv ***
// Constants, offsets and reset values of the port event notifier.
// Assumes a single switch core clock and a 32-bit Avalon-MM register bus.
package event_notifier_pkg;

	localparam int          EV_N          = 10;
	localparam int          EV_MAX_RETRY  = 0;
	localparam int          EV_BAD_TRANS  = 1;
	localparam int          EV_PARITY     = 2;
	localparam int          EV_LINK_FAIL  = 3;
	localparam int          EV_LINK_DEG   = 4;
	localparam int          EV_RESET_SYM  = 5;
	localparam int          EV_MCAST_SYM  = 6;
	localparam int          EV_EGRESS     = 7;
	localparam int          EV_INGRESS    = 8;
	localparam int          EV_REORDER    = 9;

	// Events that may also produce a port-write
	localparam logic [9:0]  PW_CAPABLE    = 10'h39f;

	localparam int          AW            = 8;
	localparam logic [7:0]  OFF_ERR_DET   = 8'h00;
	localparam logic [7:0]  OFF_INT_STAT  = 8'h04;
	localparam logic [7:0]  OFF_ERR_STAT  = 8'h08;
	localparam logic [7:0]  OFF_SYM_STAT  = 8'h0c;
	localparam logic [7:0]  OFF_GLB_STAT  = 8'h10;
	localparam logic [7:0]  OFF_INT_EN    = 8'h14;
	localparam logic [7:0]  OFF_PW_EN     = 8'h18;
	localparam logic [7:0]  OFF_RETRY_THR = 8'h1c;
	localparam logic [7:0]  OFF_EGR_LIM   = 8'h20;
	localparam logic [7:0]  OFF_ING_LIM   = 8'h24;
	localparam logic [7:0]  OFF_RDR_THR   = 8'h28;
	localparam logic [7:0]  OFF_RATE_THR  = 8'h2c;

	localparam logic [7:0]  RETRY_THR_RST = 8'h10;
	localparam logic [15:0] EGR_LIM_RST   = 16'h0010;
	localparam logic [15:0] ING_LIM_RST   = 16'h0010;
	localparam logic [15:0] RDR_THR_RST   = 16'hffff;
	localparam logic [7:0]  FAIL_THR_RST  = 8'hff;
	localparam logic [7:0]  DEG_THR_RST   = 8'h80;
	localparam logic [2:0]  RST_SYM_COUNT = 3'h4;

endpackage

// *** hw/threshold_counter.sv ***
// Event counter that pulses when its count reaches a threshold.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module threshold_counter #(
	parameter int W = 16
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         inc,
	input  wire logic         clr,
	input  wire logic [W-1:0] thr,
	output logic              hit
);
	typedef struct packed {
		logic [W-1:0] count;
	} cnt_state_t;

	cnt_state_t s_q;
	cnt_state_t s_d;

	always_comb begin
		s_d = s_q;
		hit = inc && (W'(s_q.count + 1'b1) == thr);
		if (hit || clr) begin
			s_d.count = '0;
		end else if (inc) begin
			s_d.count = W'(s_q.count + 1'b1);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	chk_count_zeroed: assert property (@(posedge clock) disable iff (!reset_n)
		(hit || clr) |=> (s_q.count == '0))
		else $error("counter not cleared");

endmodule // threshold_counter
`default_nettype wire

// *** hw/switch_port_event_notifier.sv ***
// Port event detection with sticky flags, interrupt and port-write.
// Assumes event inputs come from same-clock logic; Avalon-MM slave.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module switch_port_event_notifier
	import event_notifier_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        retry_symbol,
	input  wire logic        pkt_accepted,
	input  wire logic        pkt_not_accepted,
	input  wire logic        pkt_valid,
	input  wire logic        lut_unmapped,
	input  wire logic        tt_reserved,
	input  wire logic        pkt_is_maint,
	input  wire logic [7:0]  hop_count,
	input  wire logic        lut_parity_error,
	input  wire logic [7:0]  err_rate_count,
	input  wire logic        reset_request_symbol,
	input  wire logic        other_symbol,
	input  wire logic        multicast_symbol,
	input  wire logic        egress_exceeded,
	input  wire logic        ingress_exceeded,
	input  wire logic        reorder_event,
	output logic             int_n,
	output logic             pw_request,
	output logic      [9:0]  pw_events
);
	typedef struct packed {
		logic        waitreq;
		logic [31:0] rdata;
		logic        int_n;
		logic        pw_req;
		logic [9:0]  pw_ev;
		logic [9:0]  flags;
		logic        impl_err;
		logic [1:0]  glob;
		logic [9:0]  int_en;
		logic [9:0]  pw_en;
		logic [7:0]  retry_thr;
		logic [15:0] egr_lim;
		logic [15:0] ing_lim;
		logic [15:0] rdr_thr;
		logic [7:0]  fail_thr;
		logic [7:0]  deg_thr;
		logic [7:0]  rate_prev;
	} state_t;

	localparam state_t STATE_RST = '{
		waitreq:   1'b1,
		rdata:     '0,
		int_n:     1'b1,
		pw_req:    1'b0,
		pw_ev:     '0,
		flags:     '0,
		impl_err:  1'b0,
		glob:      '0,
		int_en:    '0,
		pw_en:     '0,
		retry_thr: RETRY_THR_RST,
		egr_lim:   EGR_LIM_RST,
		ing_lim:   ING_LIM_RST,
		rdr_thr:   RDR_THR_RST,
		fail_thr:  FAIL_THR_RST,
		deg_thr:   DEG_THR_RST,
		rate_prev: '0
	};

	state_t s_q;
	state_t s_d;

	logic       retry_hit;
	logic       rsym_hit;
	logic       egr_hit;
	logic       ing_hit;
	logic       rdr_hit;
	logic [9:0] ev;
	logic       wr_go;
	logic [31:0] wmask;
	logic [31:0] wbits;

	// Byte-enable mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Count sits at a threshold it was not at before
	function automatic logic reached(input logic [7:0] cnt,
		input logic [7:0] prev, input logic [7:0] thr);
		reached = (cnt == thr) && (prev != thr);
	endfunction

	// Shared retry counter (one per port)
	threshold_counter #(.W(8)) u_retry (
		.clock   (clock),
		.reset_n (reset_n),
		.inc     (retry_symbol),
		.clr     (pkt_accepted | pkt_not_accepted),
		.thr     (s_q.retry_thr),
		.hit     (retry_hit)
	);

	threshold_counter #(.W(3)) u_rsym (
		.clock   (clock),
		.reset_n (reset_n),
		.inc     (reset_request_symbol),
		.clr     (other_symbol),
		.thr     (RST_SYM_COUNT),
		.hit     (rsym_hit)
	);

	threshold_counter #(.W(16)) u_egr (
		.clock   (clock),
		.reset_n (reset_n),
		.inc     (egress_exceeded),
		.clr     (1'b0),
		.thr     (s_q.egr_lim),
		.hit     (egr_hit)
	);

	threshold_counter #(.W(16)) u_ing (
		.clock   (clock),
		.reset_n (reset_n),
		.inc     (ingress_exceeded),
		.clr     (1'b0),
		.thr     (s_q.ing_lim),
		.hit     (ing_hit)
	);

	threshold_counter #(.W(16)) u_rdr (
		.clock   (clock),
		.reset_n (reset_n),
		.inc     (reorder_event),
		.clr     (1'b0),
		.thr     (s_q.rdr_thr),
		.hit     (rdr_hit)
	);

	always_comb begin
		ev = '0;
		ev[EV_MAX_RETRY] = retry_hit;
		ev[EV_BAD_TRANS] = pkt_valid && (lut_unmapped || tt_reserved
			|| (pkt_is_maint && (hop_count != 8'h00)));
		ev[EV_PARITY]    = lut_parity_error;
		ev[EV_LINK_FAIL] = reached(err_rate_count, s_q.rate_prev,
			s_q.fail_thr);
		ev[EV_LINK_DEG]  = reached(err_rate_count, s_q.rate_prev,
			s_q.deg_thr);
		ev[EV_RESET_SYM] = rsym_hit;
		ev[EV_MCAST_SYM] = multicast_symbol;
		ev[EV_EGRESS]    = egr_hit;
		ev[EV_INGRESS]   = ing_hit;
		ev[EV_REORDER]   = rdr_hit;
	end

	assign wr_go = avs_write && !s_q.waitreq;
	assign wmask = lane_mask(avs_byteenable);
	assign wbits = avs_writedata & wmask;

	always_comb begin
		s_d = s_q;
		s_d.rate_prev = err_rate_count;
		// One wait state, then answer
		s_d.waitreq = !((avs_read || avs_write) && s_q.waitreq);
		if (avs_read && s_q.waitreq) begin
			case (avs_address)
				OFF_ERR_DET:   s_d.rdata = {31'h0, s_q.impl_err};
				OFF_INT_STAT:  s_d.rdata = {26'h0, s_q.flags[9:7],
					s_q.flags[2:0]};
				OFF_ERR_STAT:  s_d.rdata = {30'h0, s_q.flags[4:3]};
				OFF_SYM_STAT:  s_d.rdata = {30'h0, s_q.flags[6:5]};
				OFF_GLB_STAT:  s_d.rdata = {30'h0, s_q.glob};
				OFF_INT_EN:    s_d.rdata = {22'h0, s_q.int_en};
				OFF_PW_EN:     s_d.rdata = {22'h0, s_q.pw_en};
				OFF_RETRY_THR: s_d.rdata = {24'h0, s_q.retry_thr};
				OFF_EGR_LIM:   s_d.rdata = {16'h0, s_q.egr_lim};
				OFF_ING_LIM:   s_d.rdata = {16'h0, s_q.ing_lim};
				OFF_RDR_THR:   s_d.rdata = {16'h0, s_q.rdr_thr};
				OFF_RATE_THR:  s_d.rdata = {16'h0, s_q.deg_thr,
					s_q.fail_thr};
				default:       s_d.rdata = '0;
			endcase
		end
		if (wr_go) begin
			case (avs_address)
				OFF_ERR_DET:   s_d.impl_err = s_q.impl_err & ~wbits[0];
				OFF_INT_STAT: begin
					s_d.flags[2:0] = s_q.flags[2:0] & ~wbits[2:0];
					s_d.flags[9:7] = s_q.flags[9:7] & ~wbits[5:3];
				end
				OFF_ERR_STAT:  s_d.flags[4:3] = s_q.flags[4:3] & ~wbits[1:0];
				OFF_SYM_STAT:  s_d.flags[6:5] = s_q.flags[6:5] & ~wbits[1:0];
				OFF_GLB_STAT:  s_d.glob = s_q.glob & ~wbits[1:0];
				OFF_INT_EN:    s_d.int_en = 10'((s_q.int_en & ~wmask[9:0])
					| wbits[9:0]);
				OFF_PW_EN:     s_d.pw_en = 10'((s_q.pw_en & ~wmask[9:0])
					| wbits[9:0]);
				OFF_RETRY_THR: s_d.retry_thr = 8'((s_q.retry_thr
					& ~wmask[7:0]) | wbits[7:0]);
				OFF_EGR_LIM:   s_d.egr_lim = 16'((s_q.egr_lim
					& ~wmask[15:0]) | wbits[15:0]);
				OFF_ING_LIM:   s_d.ing_lim = 16'((s_q.ing_lim
					& ~wmask[15:0]) | wbits[15:0]);
				OFF_RDR_THR:   s_d.rdr_thr = 16'((s_q.rdr_thr
					& ~wmask[15:0]) | wbits[15:0]);
				OFF_RATE_THR: begin
					s_d.fail_thr = 8'((s_q.fail_thr & ~wmask[7:0])
						| wbits[7:0]);
					s_d.deg_thr = 8'((s_q.deg_thr & ~wmask[15:8])
						| wbits[15:8]);
				end
				default: ;
			endcase
		end
		s_d.flags = s_d.flags | ev;
		if (ev[EV_MAX_RETRY] || ev[EV_BAD_TRANS] || ev[EV_PARITY]) begin
			s_d.impl_err = 1'b1;
		end
		s_d.glob = s_d.glob | ev[EV_MCAST_SYM:EV_RESET_SYM];
		s_d.int_n = !(|(s_d.flags & s_d.int_en));
		s_d.pw_ev = ev & s_q.pw_en & PW_CAPABLE;
		s_d.pw_req = |s_d.pw_ev;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign int_n           = s_q.int_n;
	assign pw_request      = s_q.pw_req;
	assign pw_events       = s_q.pw_ev;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	chk_retry_flags: assert property (retry_hit |=>
		s_q.flags[EV_MAX_RETRY] && s_q.impl_err)
		else $error("retry event not flagged");
	chk_illegal_flag: assert property (pkt_valid && pkt_is_maint
		&& hop_count != 8'h00 |=> s_q.flags[EV_BAD_TRANS] && s_q.impl_err)
		else $error("illegal transaction not flagged");
	chk_parity_flag: assert property (lut_parity_error |=>
		s_q.flags[EV_PARITY] && s_q.impl_err)
		else $error("parity error not flagged");
	chk_fail_flag: assert property (err_rate_count == s_q.fail_thr
		&& s_q.rate_prev != s_q.fail_thr |=> s_q.flags[EV_LINK_FAIL])
		else $error("link failed not flagged");
	chk_symbol_no_pw: assert property (
		(pw_events & ~PW_CAPABLE) == 10'h000)
		else $error("symbol event sent port-write");
	chk_mcast_global: assert property (multicast_symbol |=>
		s_q.flags[EV_MCAST_SYM] && s_q.glob[1])
		else $error("multicast symbol not flagged");
	chk_pw_enabled: assert property (pw_request |->
		(pw_events & ~$past(s_q.pw_en)) == 10'h000)
		else $error("port-write for disabled event");
	chk_int_follows: assert property (|(s_q.flags & s_q.int_en)
		|-> !int_n)
		else $error("interrupt not asserted");
	chk_flag_sticky: assert property (|($past(s_q.flags) & ~s_q.flags)
		|-> $past(wr_go))
		else $error("flag cleared without write");
	chk_reorder_hit: assert property (rdr_hit |=>
		s_q.flags[EV_REORDER] ##1 s_q.flags[EV_REORDER] || $past(wr_go))
		else $error("reorder not flagged");
	chk_bus_answer: assert property ((avs_read || avs_write)
		&& avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

	cov_retry_event: cover property (retry_hit ##1 !int_n);
	cov_port_write: cover property (pw_request && $countones(pw_events) > 1);
	cov_reset_sym: cover property (rsym_hit ##1 s_q.glob[0]);

endmodule // switch_port_event_notifier
`default_nettype wire

// *** verification/link_partner_model.sv ***
// Link partner model: turns one-cycle requests into event pulses.
// Assumes requests change just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [10:0] fire,
	input  wire logic [7:0]  rate,
	output logic      [10:0] pulse,
	output logic      [7:0]  err_rate_count
);
	// Symbols, packets and the error count leave one clock later
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pulse <= '0;
			err_rate_count <= '0;
		end else begin
			pulse <= fire;
			err_rate_count <= rate;
		end
	end
endmodule // link_partner_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Table-driven bench for the port event notifier.
// Assumes the partner model drives the event pulses and error count; the bench drives the packet qualifiers.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import event_notifier_pkg::*;
	typedef struct {
		logic [10:0] f;
		logic [2:0]  q;
		logic [7:0]  hop;
		logic [7:0]  off;
		logic [31:0] exp;
		logic [31:0] ed;
		logic [9:0]  pw;
	} row_t;
	logic        clock, reset_n, avs_read, avs_write;
	logic [7:0]  avs_address, hop_count, rate, err_rate_count;
	logic [31:0] avs_writedata, avs_readdata, rd_q;
	logic [3:0]  avs_byteenable;
	logic        avs_waitrequest, int_n, pw_request;
	logic        lut_unmapped, tt_reserved, pkt_is_maint;
	logic [9:0]  pw_events, pwe_seen;
	logic [10:0] fire, pulse;
	logic        pw_seen, int_seen;
	int          fails, n_compared, cycles;
	row_t rows [8] = '{
		'{11'h010, 3'b000, 8'h00, OFF_INT_STAT, 32'h4, 32'h1, 10'h004},
		'{11'h008, 3'b100, 8'h00, OFF_INT_STAT, 32'h2, 32'h1, 10'h002},
		'{11'h008, 3'b010, 8'h00, OFF_INT_STAT, 32'h2, 32'h1, 10'h002},
		'{11'h008, 3'b001, 8'h03, OFF_INT_STAT, 32'h2, 32'h1, 10'h002},
		'{11'h008, 3'b001, 8'h00, OFF_INT_STAT, 32'h0, 32'h0, 10'h000},
		'{11'h090, 3'b000, 8'h00, OFF_SYM_STAT, 32'h2, 32'h1, 10'h004},
		'{11'h018, 3'b100, 8'h00, OFF_INT_STAT, 32'h6, 32'h1, 10'h006},
		'{11'h080, 3'b000, 8'h00, OFF_GLB_STAT, 32'h2, 32'h0, 10'h000}};
	logic [10:0] rseq [8] = '{11'h1, 11'h1, 11'h2, 11'h1, 11'h1, 11'h4,
		11'h1, 11'h1};
	logic [10:0] sseq [7] = '{11'h20, 11'h20, 11'h20, 11'h40, 11'h20,
		11'h20, 11'h20};
	logic [7:0]  loff [3] = '{OFF_EGR_LIM, OFF_ING_LIM, OFF_RDR_THR};

	link_partner_model partner (.clock(clock), .reset_n(reset_n),
		.fire(fire), .rate(rate), .pulse(pulse),
		.err_rate_count(err_rate_count));

	switch_port_event_notifier DUT (.clock(clock), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .retry_symbol(pulse[0]),
		.pkt_accepted(pulse[1]), .pkt_not_accepted(pulse[2]),
		.pkt_valid(pulse[3]), .lut_unmapped(lut_unmapped),
		.tt_reserved(tt_reserved), .pkt_is_maint(pkt_is_maint),
		.hop_count(hop_count), .lut_parity_error(pulse[4]),
		.err_rate_count(err_rate_count),
		.reset_request_symbol(pulse[5]), .other_symbol(pulse[6]),
		.multicast_symbol(pulse[7]), .egress_exceeded(pulse[8]),
		.ingress_exceeded(pulse[9]), .reorder_event(pulse[10]),
		.int_n(int_n), .pw_request(pw_request), .pw_events(pw_events));

	always #50 clock = ~clock;

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// Hold the request until waitrequest is sampled low at an edge
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd_q, e);
	endtask

	task automatic clr_all();
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 8'(i * 4), 32'hffffffff);
		end
		repeat (2) @(negedge clock);
	endtask

	task automatic ev(input logic [10:0] v, input logic [7:0] rt);
		@(posedge clock);
		fire <= v;
		rate <= rt;
		@(posedge clock);
		fire <= '0;
		@(posedge clock);
		@(negedge clock);
		pw_seen = pw_request;
		pwe_seen = pw_events;
		int_seen = int_n;
	endtask

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		{lut_unmapped, tt_reserved, pkt_is_maint, hop_count} = '0;
		fire = '0;
		rate = '0;
		{fails, n_compared, cycles} = '0;
		repeat (2) @(posedge clock);
		check({int_n, pw_request, avs_waitrequest}, 32'h5);
		reset_n <= 1'b1;
		rchk(OFF_RDR_THR, {16'h0, RDR_THR_RST});
		rchk(OFF_RATE_THR, {16'h0, DEG_THR_RST, FAIL_THR_RST});
		bus(1'b1, 8'h3c, 32'hffffffff);
		rchk(8'h3c, 32'h0);
		bus(1'b1, OFF_INT_EN, 32'h3ff);
		bus(1'b1, OFF_PW_EN, 32'h3ff);
		foreach (rows[i]) begin
			@(posedge clock);
			{lut_unmapped, tt_reserved, pkt_is_maint} <= rows[i].q;
			hop_count <= rows[i].hop;
			ev(rows[i].f, 8'h0);
			check({pw_seen, pwe_seen, int_seen}, {|rows[i].pw, rows[i].pw,
				rows[i].exp == 0});
			rchk(rows[i].off, rows[i].exp);
			rchk(OFF_ERR_DET, rows[i].ed);
			clr_all();
			check(int_n, 32'h1);
		end
		bus(1'b1, OFF_RETRY_THR, 32'h3);
		foreach (rseq[i]) ev(rseq[i], 8'h0);
		rchk(OFF_INT_STAT, 32'h0);
		ev(11'h1, 8'h0);
		check({pw_seen, pwe_seen}, {1'b1, 10'h001});
		rchk(OFF_INT_STAT, 32'h1);
		rchk(OFF_ERR_DET, 32'h1);
		clr_all();
		ev(11'h1, 8'h0);
		ev(11'h1, 8'h0);
		rchk(OFF_INT_STAT, 32'h0);
		ev(11'h1, 8'h0);
		rchk(OFF_INT_STAT, 32'h1);
		clr_all();
		foreach (sseq[i]) ev(sseq[i], 8'h0);
		rchk(OFF_SYM_STAT, 32'h0);
		ev(11'h20, 8'h0);
		check({pw_seen, int_seen}, 32'h0);
		rchk(OFF_SYM_STAT, 32'h1);
		rchk(OFF_GLB_STAT, 32'h1);
		clr_all();
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, loff[k], 32'h2);
			ev(11'h100 << k, 8'h0);
			rchk(OFF_INT_STAT, 32'h0);
			ev(11'h100 << k, 8'h0);
			check(pwe_seen, 10'h080 << k);
			rchk(OFF_INT_STAT, 32'h8 << k);
			clr_all();
		end
		bus(1'b1, OFF_RATE_THR, 32'h0305);
		ev(11'h0, 8'h3);
		check(pwe_seen, 10'h010);
		ev(11'h0, 8'h5);
		check(pwe_seen, 10'h008);
		rchk(OFF_ERR_STAT, 32'h3);
		clr_all();
		bus(1'b1, OFF_INT_EN, 32'h0);
		ev(11'h010, 8'h5);
		check({pw_seen, int_seen}, 32'h3);
		repeat (20) @(negedge clock);
		rchk(OFF_INT_STAT, 32'h4);
		bus(1'b1, OFF_INT_EN, 32'h3ff);
		repeat (2) @(negedge clock);
		check(int_n, 32'h0);
		bus(1'b1, OFF_PW_EN, 32'h0);
		ev(11'h010, 8'h5);
		check(pw_seen, 32'h0);
		@(posedge clock);
		reset_n <= 1'b0;
		@(negedge clock);
		check({int_n, pw_request, avs_waitrequest}, 32'h5);
		@(posedge clock);
		reset_n <= 1'b1;
		rchk(OFF_INT_EN, 32'h0);
		rchk(OFF_RDR_THR, {16'h0, RDR_THR_RST});
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
